// File: rtl/phase_overcurrent_front_end.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "phase_oc_map.svh"
// Function
// - magnitude selectable: RMS, true RMS, peak-to-peak
// - peak-to-peak taken from raw samples
// - eight parameter groups, one common selector
// - group and blocking change live
// - instant, definite or inverse time delay
// - saturation check keeps pick-up correct
// - fixed processing order per refresh
// - three phases, one common pick-up
// - start, trip, blocked outputs provided
// - time-stamped event on each output edge
// - instant mode: start and trip together
// - event stamps have millisecond resolution
// - clearable start, trip, blocked counters
// - pre-fault value is 20 ms average
// - input channel chosen by setting
// - pick up any phase, drop at 97%
// - start only while blocking inactive
// - selection codes 1, 2, 3
module phase_overcurrent_front_end #(
  parameter int                 MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
  parameter phase_oc_pkg::mag_t SAT_LEVEL = 16'hff00,
  parameter int                 CNT_W     = 16
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register port
  input  wire logic [7:0]                 addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic [31:0]                     rdata,
  // measurement source
  input  wire phase_oc_pkg::three_phase_t meas_ch0,
  input  wire phase_oc_pkg::three_phase_t meas_ch1,
  input  wire logic                       meas_valid,
  input  wire logic signed [15:0]         raw_a,
  input  wire logic signed [15:0]         raw_b,
  input  wire logic signed [15:0]         raw_c,
  input  wire logic                       raw_valid,
  // blocking pin
  input  wire logic                       block_in,
  // protection outputs
  output logic                            start_out,
  output logic                            trip_out,
  output logic                            blocked_out,
  output phase_oc_pkg::event_s            event_out,
  output phase_oc_pkg::mag_t              prefault
);
  localparam int DIV_W  = $clog2(MS_CYCLES);
  localparam int HIST_N = `PREFAULT_MS / `REFRESH_MS;

  // ****************************************
  // register file
  // ****************************************
  logic [31:0]        ctrl;
  logic [15:0]        pickup_grp [8];
  logic [31:0]        delay_grp  [8];
  wire                wr_ctrl  = wr_en && addr == `REG_CTRL;
  wire                wr_clear = wr_en && addr == `REG_CLEAR;
  wire                grp_hit  = addr[7:6] == `GROUP_BASE;
  wire [2:0]          grp_idx  = addr[5:3];
  wire [2:0]          group    = ctrl[`F_GROUP];
  wire [1:0]          mag_sel  = ctrl[`F_MAG_SEL];
  wire phase_oc_pkg::mag_t pickup_level = pickup_grp[group];
  wire [1:0]          dly_mode  = delay_grp[group][`F_MODE];
  wire [1:0]          dly_curve = delay_grp[group][`F_CURVE];
  wire [15:0]         dly_time  = delay_grp[group][`F_TIME];

  // settings change any time; the function reads the live group each cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      for (int g = 0; g < 8; g++) begin
        pickup_grp[g] <= `PICKUP_RESET;
        delay_grp[g]  <= `DELAY_RESET;
      end
    end else begin
      if (wr_ctrl)
        ctrl <= {25'h0, wdata[6:0]};
      if (wr_en && grp_hit && !addr[2])
        pickup_grp[grp_idx] <= wdata[15:0];
      if (wr_en && grp_hit && addr[2])
        delay_grp[grp_idx] <= wdata;
    end
  end

  // ****************************************
  // time base and blocking input
  // ****************************************
  logic [DIV_W-1:0] div_cnt;
  logic             ms_tick;
  logic [31:0]      ms_count;
  logic [2:0]       blk_sync;
  logic             blk_q;

  // one-cycle enable every millisecond drives stamps and timers
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt  <= '0;
      ms_tick  <= 1'b0;
      ms_count <= 32'h0;
    end else begin
      ms_tick <= div_cnt == DIV_W'(MS_CYCLES - 1);
      div_cnt <= (div_cnt == DIV_W'(MS_CYCLES - 1)) ? '0 : div_cnt + 1'b1;
      if (ms_tick)
        ms_count <= ms_count + 32'h1;
    end
  end

  // pin crosses three flops; a change counts once the last two agree
  always_ff @(posedge clk) begin
    if (rst) begin
      blk_sync <= 3'h0;
      blk_q    <= 1'b0;
    end else begin
      blk_sync <= {blk_sync[1:0], block_in};
      if (blk_sync[2] == blk_sync[1])
        blk_q <= blk_sync[2];
    end
  end

  // ****************************************
  // magnitude selection and processing
  // ****************************************
  wire signed [15:0]           raw [3] = '{raw_a, raw_b, raw_c};
  wire phase_oc_pkg::three_phase_t chan = ctrl[`F_CHAN] ? meas_ch1 : meas_ch0;
  logic signed [15:0]          pk_max [3];
  logic signed [15:0]          pk_min [3];
  phase_oc_pkg::mag_t          pp_raw [3];
  phase_oc_pkg::mag_t          sel    [3];
  logic [2:0]                  sat, over, under;
  logic                        v1, v2;
  logic                        picked;

  for (genvar i = 0; i < 3; i++) begin : g_phase
    // peak-to-peak from raw samples, window closes on each refresh
    always_ff @(posedge clk) begin
      if (rst) begin
        pk_max[i] <= 16'sh8000;
        pk_min[i] <= 16'sh7fff;
        pp_raw[i] <= 16'h0;
      end else if (meas_valid) begin
        pp_raw[i] <= 16'(pk_max[i] - pk_min[i]);
        pk_max[i] <= 16'sh8000;
        pk_min[i] <= 16'sh7fff;
      end else if (raw_valid) begin
        if (raw[i] > pk_max[i])
          pk_max[i] <= raw[i];
        if (raw[i] < pk_min[i])
          pk_min[i] <= raw[i];
      end
    end
    wire phase_oc_pkg::mag_t pick_mag =
      (mag_sel == phase_oc_pkg::MAG_TRUE_RMS) ? chan[i].true_rms :
      (mag_sel == phase_oc_pkg::MAG_PEAK)     ? pp_raw[i] : chan[i].rms;
    // stage one selects and flags saturation, stage two compares
    always_ff @(posedge clk) begin
      if (rst) begin
        sel[i]   <= 16'h0;
        sat[i]   <= 1'b0;
        over[i]  <= 1'b0;
        under[i] <= 1'b1;
      end else begin
        if (meas_valid) begin
          sel[i] <= pick_mag;
          sat[i] <= pp_raw[i] >= SAT_LEVEL;
        end
        if (v1) begin
          // a clipped transformer reads low, so saturation counts as over
          over[i]  <= sat[i] || sel[i] > pickup_level;
          under[i] <= !sat[i] && 23'(sel[i]) * `FULL_PCT < 23'(pickup_level) * `DROPOUT_PCT;
        end
      end
    end
  end

  // stage three: pick up on any phase, drop only when all are below 97 %
  always_ff @(posedge clk) begin
    if (rst) begin
      v1     <= 1'b0;
      v2     <= 1'b0;
      picked <= 1'b0;
    end else begin
      v1 <= meas_valid;
      v2 <= v1;
      if (v2 && |over)
        picked <= 1'b1;
      else if (v2 && &under)
        picked <= 1'b0;
    end
  end

  // ****************************************
  // blocking, time delay and outputs
  // ****************************************
  phase_oc_pkg::prot_state_e state, next_state;
  logic [15:0]               timer_ms;
  logic [31:0]               idmt_acc;
  wire phase_oc_pkg::mag_t   sel_max = (sel[0] > sel[1]) ? ((sel[0] > sel[2]) ? sel[0] : sel[2])
                                                         : ((sel[1] > sel[2]) ? sel[1] : sel[2]);
  wire [15:0]                excess = (sel_max > pickup_level) ? sel_max - pickup_level : 16'h0;
  wire                       dt_due   = timer_ms >= dly_time;
  wire                       idmt_due = idmt_acc >= 32'(dly_time) * 32'(pickup_level);
  wire                       due = (dly_mode == phase_oc_pkg::MODE_IDMT) ? idmt_due : dt_due;
  wire                       instant = dly_mode == phase_oc_pkg::MODE_INSTANT;

  // blocking is checked right after pick-up, before the delay; a start only exists while unblocked
  always_comb begin
    next_state = state;
    case (state)
      phase_oc_pkg::ST_IDLE:
        if (picked)
          next_state = blk_q ? phase_oc_pkg::ST_BLOCK :
                       instant ? phase_oc_pkg::ST_TRIP : phase_oc_pkg::ST_START;
      phase_oc_pkg::ST_START:
        if (!picked)
          next_state = phase_oc_pkg::ST_IDLE;
        else if (blk_q)
          next_state = phase_oc_pkg::ST_BLOCK;
        else if (due)
          next_state = phase_oc_pkg::ST_TRIP;
      phase_oc_pkg::ST_TRIP:
        if (!picked)
          next_state = phase_oc_pkg::ST_IDLE;
        else if (blk_q)
          next_state = phase_oc_pkg::ST_BLOCK;
      phase_oc_pkg::ST_BLOCK:
        if (!picked || !blk_q)
          next_state = phase_oc_pkg::ST_IDLE;
      default:
        next_state = phase_oc_pkg::ST_IDLE;
    endcase
  end

  wire next_start = next_state == phase_oc_pkg::ST_START || next_state == phase_oc_pkg::ST_TRIP;
  wire next_trip  = next_state == phase_oc_pkg::ST_TRIP;
  wire next_blk   = next_state == phase_oc_pkg::ST_BLOCK;
  wire [2:0] chg  = {next_start ^ start_out, next_trip ^ trip_out, next_blk ^ blocked_out};

  // outputs and their event word share one edge, so stamps match
  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= phase_oc_pkg::ST_IDLE;
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
      event_out   <= '0;
    end else begin
      state       <= next_state;
      start_out   <= next_start;
      trip_out    <= next_trip;
      blocked_out <= next_blk;
      event_out   <= '{valid: |chg, start_chg: chg[2], trip_chg: chg[1], block_chg: chg[0],
                       start: next_start, trip: next_trip, blocked: next_blk,
                       stamp: ms_count};
    end
  end

  // operate timers run only while started; integral of excess gives inverse time
  always_ff @(posedge clk) begin
    if (rst || state != phase_oc_pkg::ST_START) begin
      timer_ms <= 16'h0;
      idmt_acc <= 32'h0;
    end else if (ms_tick) begin
      if (timer_ms != 16'hffff)
        timer_ms <= timer_ms + 16'h1;
      idmt_acc <= idmt_acc + 32'({excess, 3'h0} >> (2'h3 - dly_curve));
    end
  end

  // ****************************************
  // counters and pre-fault history
  // ****************************************
  logic [CNT_W-1:0]   cnt_start, cnt_trip, cnt_block;
  phase_oc_pkg::mag_t hist [HIST_N];
  logic [17:0]        hist_sum;
  wire [2:0]          clr = wr_clear ? wdata[2:0] : 3'h0;
  wire                up_start = event_out.start_chg && event_out.start;
  wire                up_trip  = event_out.trip_chg && event_out.trip;
  wire                up_block = event_out.block_chg && event_out.blocked;
  wire phase_oc_pkg::mag_t hist_avg = 16'(hist_sum / 18'(HIST_N));

  always_comb begin
    hist_sum = 18'h0;
    for (int k = 0; k < HIST_N; k++)
      hist_sum = hist_sum + 18'(hist[k]);
  end

  // an edge in the clearing cycle still counts: set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_start <= '0;
      cnt_trip  <= '0;
      cnt_block <= '0;
    end else begin
      cnt_start <= up_start ? (clr[0] ? CNT_W'(1) : cnt_start + 1'b1) : (clr[0] ? '0 : cnt_start);
      cnt_trip  <= up_trip  ? (clr[1] ? CNT_W'(1) : cnt_trip + 1'b1)  : (clr[1] ? '0 : cnt_trip);
      cnt_block <= up_block ? (clr[2] ? CNT_W'(1) : cnt_block + 1'b1) : (clr[2] ? '0 : cnt_block);
    end
  end

  // one entry per 5 ms refresh; the window ends at the start or trip edge
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < HIST_N; k++)
        hist[k] <= 16'h0;
      prefault <= 16'h0;
    end else begin
      if (v1) begin
        hist[0] <= sel_max;
        for (int k = 1; k < HIST_N; k++)
          hist[k] <= hist[k-1];
      end
      if (up_start || up_trip)
        prefault <= hist_avg;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  wire [31:0] status  = {21'h0, group, state, picked, blocked_out, trip_out, start_out};
  wire [31:0] grp_rd  = addr[2] ? delay_grp[grp_idx] : {16'h0, pickup_grp[grp_idx]};
  wire [31:0] rd_mux  = (addr == `REG_CTRL)      ? ctrl :
                        (addr == `REG_STATUS)    ? status :
                        (addr == `REG_CNT_START) ? 32'(cnt_start) :
                        (addr == `REG_CNT_TRIP)  ? 32'(cnt_trip) :
                        (addr == `REG_CNT_BLOCK) ? 32'(cnt_block) :
                        (addr == `REG_PREFAULT)  ? {16'h0, prefault} :
                        (addr == `REG_STAMP)     ? ms_count :
                        grp_hit                  ? grp_rd : 32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst)
      rdata <= 32'h0;
    else
      rdata <= rd_en ? rd_mux : 32'h0;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start_rise;
    $rose(start_out);
  endsequence

  a_start_not_blocked: assert property (start_out |-> !blocked_out) else $error("start while blocked");
  a_event_on_edge: assert property ($changed({start_out, trip_out, blocked_out}) |-> event_out.valid)
    else $error("output edge without event");
  a_instant_pair: assert property ($rose(trip_out) && $past(instant) && !$past(start_out)
    |-> event_out.start_chg && event_out.trip_chg) else $error("instant events split");
  a_stamp_ms: assert property (event_out.valid |-> event_out.stamp == $past(ms_count))
    else $error("event stamp mismatch");
  a_ms_advance: assert property (ms_tick |=> ms_count == $past(ms_count) + 32'h1)
    else $error("millisecond count stuck");
  a_count_start: assert property (s_start_rise |=> cnt_start == ($past(clr[0]) ? CNT_W'(1) : $past(cnt_start) + 1'b1))
    else $error("start count wrong");
  a_pickup_cause: assert property (s_start_rise |-> $past(picked) && !$past(blk_q))
    else $error("start without pick-up");
  a_block_cause: assert property ($rose(blocked_out) |-> $past(picked) && $past(blk_q))
    else $error("blocked without cause");
  a_dt_delay: assert property ($rose(trip_out) && $past(dly_mode) == phase_oc_pkg::MODE_DT
    |-> $past(timer_ms) >= $past(dly_time)) else $error("definite trip early");
  a_prefault_take: assert property (s_start_rise |=> prefault == $past(hist_avg))
    else $error("pre-fault not latched");
endmodule : phase_overcurrent_front_end

// File: rtl/phase_oc_map.svh
`ifndef PHASE_OC_MAP_SVH
`define PHASE_OC_MAP_SVH
// timing
`define CLK_PERIOD_NS 10
`define MS_NS         1000000
`define REFRESH_MS    5
`define PREFAULT_MS   20
`define DROPOUT_PCT   23'd97
`define FULL_PCT      23'd100
// register offsets
`define REG_CTRL      8'h00
`define REG_CLEAR     8'h04
`define REG_STATUS    8'h08
`define REG_CNT_START 8'h0c
`define REG_CNT_TRIP  8'h10
`define REG_CNT_BLOCK 8'h14
`define REG_PREFAULT  8'h18
`define REG_STAMP     8'h1c
`define GROUP_BASE    2'h1
// field positions
`define F_MAG_SEL     1:0
`define F_CHAN        2
`define F_GROUP       6:4
`define F_MODE        1:0
`define F_CURVE       3:2
`define F_TIME        31:16
// reset values
`define CTRL_RESET    32'h0000_0001
`define PICKUP_RESET  16'h0078
`define DELAY_RESET   32'h0028_0001
`endif

// File: rtl/phase_oc_pkg.sv
package phase_oc_pkg;
  typedef logic [15:0] mag_t;
  typedef enum logic [1:0] {MAG_RMS = 2'h1, MAG_TRUE_RMS = 2'h2, MAG_PEAK = 2'h3} mag_sel_e;
  typedef enum logic [1:0] {MODE_INSTANT = 2'h0, MODE_DT = 2'h1, MODE_IDMT = 2'h2} delay_e;
  typedef enum logic [3:0] {ST_IDLE = 4'h1, ST_START = 4'h2, ST_TRIP = 4'h4, ST_BLOCK = 4'h8} prot_state_e;
  typedef struct packed {
    mag_t rms;
    mag_t true_rms;
    mag_t peak_to_peak;
  } phase_mag_s;
  typedef phase_mag_s [2:0] three_phase_t;
  typedef struct packed {
    logic        valid;
    logic        start_chg;
    logic        trip_chg;
    logic        block_chg;
    logic        start;
    logic        trip;
    logic        blocked;
    logic [31:0] stamp;
  } event_s;
endpackage : phase_oc_pkg

// File: tb/meas_source_model.sv
`timescale 1ns/1ps
// ****************************************
// measurement source model
// ****************************************
module meas_source_model #(
  parameter int REFRESH = 50
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // values published by the bench
  input  wire phase_oc_pkg::three_phase_t set_ch0,
  input  wire phase_oc_pkg::three_phase_t set_ch1,
  input  wire logic signed [15:0]         raw_amp,
  // towards the block
  output phase_oc_pkg::three_phase_t      meas_ch0,
  output phase_oc_pkg::three_phase_t      meas_ch1,
  output logic                            meas_valid,
  output logic signed [15:0]              raw_a,
  output logic signed [15:0]              raw_b,
  output logic signed [15:0]              raw_c,
  output logic                            raw_valid
);
  int                 tick;
  logic               hi;
  wire                fire = (tick == REFRESH - 1);
  wire signed [15:0]  samp = hi ? raw_amp : -raw_amp;
  // one refresh pulse a period; raw samples alternate sign every other cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      tick       <= 0;
      meas_valid <= 1'b0;
      raw_valid  <= 1'b0;
      hi         <= 1'b0;
    end else begin
      tick       <= fire ? 0 : tick + 1;
      meas_valid <= fire;
      raw_valid  <= ~raw_valid;
      hi         <= raw_valid ? ~hi : hi;
    end
  end
  // outside its strobe a value is inverted, so a latch at the wrong edge shows up
  always_ff @(posedge clk) begin
    meas_ch0 <= fire ? set_ch0 : ~set_ch0;
    meas_ch1 <= fire ? set_ch1 : ~set_ch1;
    raw_a    <= !raw_valid ? samp : ~samp;
    raw_b    <= !raw_valid ? samp : ~samp;
    raw_c    <= !raw_valid ? samp : ~samp;
  end
endmodule : meas_source_model

// File: tb/phase_overcurrent_front_end_tb.sv
`timescale 1ns/1ps
// ****************************************
// bench for the phase overcurrent front end
// ****************************************
module phase_overcurrent_front_end_tb;
  localparam int              MS      = 10;
  localparam int              REFRESH = 5 * MS;
  localparam logic [15:0]     T_RMS [7] = '{16'h96, 16'h0, 16'h0, 16'h96, 16'h96, 16'h0, 16'h0};
  localparam logic [15:0]     T_TR  [7] = '{16'h0, 16'h96, 16'h96, 16'h0, 16'h96, 16'h0, 16'h0};
  localparam logic [15:0]     T_AMP [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'ha, 16'h64, 16'h7fff};
  localparam logic [1:0]      T_SEL [7] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1};
  localparam logic [6:0]      T_EXP     = 7'h65;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic [7:0]                 addr = 8'h00;
  logic [31:0]                wdata = 32'h0;
  logic                       wr_en = 1'b0;
  logic                       rd_en = 1'b0;
  logic                       block_in = 1'b0;
  logic signed [15:0]         raw_amp = 16'sh0;
  phase_oc_pkg::three_phase_t set_ch0 = '0;
  phase_oc_pkg::three_phase_t set_ch1 = '0;
  phase_oc_pkg::three_phase_t meas_ch0, meas_ch1;
  logic                       meas_valid, raw_valid, start_out, trip_out, blocked_out;
  logic signed [15:0]         raw_a, raw_b, raw_c;
  logic [31:0]                rdata, st_stamp, tr_stamp;
  logic [15:0]                ra, rb, rc;
  phase_oc_pkg::event_s       event_out;
  phase_oc_pkg::mag_t         prefault;
  int                         err_total = 0;
  int                         samples_checked = 0;
  int                         pairs = 0;
  int                         offs = 0;

  always #5 clk = ~clk;

  phase_overcurrent_front_end #(.MS_CYCLES(MS)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .meas_ch0(meas_ch0), .meas_ch1(meas_ch1),
    .meas_valid(meas_valid), .raw_a(raw_a), .raw_b(raw_b), .raw_c(raw_c), .raw_valid(raw_valid),
    .block_in(block_in), .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .event_out(event_out), .prefault(prefault));

  meas_source_model #(.REFRESH(REFRESH)) src (.clk(clk), .rst(rst), .set_ch0(set_ch0), .set_ch1(set_ch1),
    .raw_amp(raw_amp), .meas_ch0(meas_ch0), .meas_ch1(meas_ch1), .meas_valid(meas_valid), .raw_a(raw_a),
    .raw_b(raw_b), .raw_c(raw_c), .raw_valid(raw_valid));

  // ****************************************
  // event watcher
  // ****************************************
  // stamps of the last start and trip rise, and start-with-trip pairs
  always @(posedge clk) begin
    if (event_out.valid === 1'b1) begin
      if (event_out.start_chg && event_out.start) st_stamp = event_out.stamp;
      if (event_out.trip_chg && event_out.trip) tr_stamp = event_out.stamp;
      if (event_out.start_chg && !event_out.start) offs++;
      if (event_out.start_chg && event_out.trip_chg && event_out.trip) pairs++;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic phase_oc_pkg::three_phase_t mk(input logic [15:0] a, b, c, t);
    phase_oc_pkg::three_phase_t v;
    v = '0;
    v[0].rms      = a;
    v[1].rms      = b;
    v[2].rms      = c;
    v[0].true_rms = t;
    return v;
  endfunction : mk
  // any phase above the common pick-up level
  function automatic logic exp_pick(input logic [15:0] a, b, c, lvl);
    return (a > lvl) || (b > lvl) || (c > lvl);
  endfunction : exp_pick
  function automatic logic outs(input int sel);
    case (sel)
      0: return start_out;
      1: return trip_out;
      default: return blocked_out;
    endcase
  endfunction : outs
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %h wanted %h", $time, msg, seen, exp);
    end
  endtask : check
  // an idle edge first, so back-to-back calls never reassign a strobe in one step
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_wr
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rdata, exp, msg);
  endtask : rd_chk
  // bounded wait; running out ends the run
  task automatic wait_for(input int sel, input logic val, input int bound);
    int n;
    n = 0;
    while (outs(sel) !== val && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (outs(sel) !== val) begin
      err_total++;
      $display("unexpected at %0t: wait expired on output %0d", $time, sel);
      conclude();
    end
  endtask : wait_for
  task automatic settle();
    repeat (3 * REFRESH) @(posedge clk);
  endtask : settle
  task automatic calm(input logic [15:0] t);
    set_ch0 <= '0;
    set_ch1 <= '0;
    raw_amp <= 16'sh0;
    wait_for(0, 1'b0, 400);
    $display("test %0d done", t);
  endtask : calm

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hb0b0));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(8'h00, 32'h1, "ctrl reset");
    rd_chk(8'h78, 32'h78, "group 7 pickup");
    rd_chk(8'h44, 32'h0028_0001, "delay reset");
    rd_chk(8'h08, 32'h10, "status idle");
    rd_chk(8'h3c, 32'h0, "unmapped");
    reg_wr(8'h40, 32'h64);
    reg_wr(8'h44, 32'h0);
    // instant: start and trip rise together
    set_ch0 <= mk(16'($urandom_range(0, 90)), 16'h96, 16'($urandom_range(0, 90)), 16'h0);
    wait_for(0, 1'b1, 200);
    check(trip_out, 1'b1, "instant trip");
    @(posedge clk);
    check(pairs, 1, "paired event");
    rd_chk(8'h0c, 32'h1, "start count");
    // hysteresis: 98 % keeps it, 96 % drops it
    set_ch0 <= mk(16'h0, 16'h62, 16'h0, 16'h0);
    settle();
    check(start_out, 1'b1, "held above 97");
    set_ch0 <= mk(16'h0, 16'h60, 16'h0, 16'h0);
    wait_for(0, 1'b0, 200);
    @(posedge clk);
    check(offs, 1, "start off event");
    rd_chk(8'h0c, 32'h1, "count held");
    reg_wr(8'h04, 32'h1);
    rd_chk(8'h0c, 32'h0, "count cleared");
    calm(16'h1);
    // random phase mixes against the common level
    for (int i = 0; i < 4; i++) begin
      ra = 16'($urandom_range(0, 199));
      rb = 16'($urandom_range(0, 199));
      rc = 16'($urandom_range(0, 199));
      set_ch0 <= mk(ra, rb, rc, 16'h0);
      settle();
      check(start_out, exp_pick(ra, rb, rc, 16'h64), "random mix");
      calm(16'h2);
    end
    // definite time of 3 ms
    reg_wr(8'h04, 32'h7);
    reg_wr(8'h44, 32'h0003_0001);
    // three silent refreshes, so the pre-fault window holds one loud entry in four
    settle();
    set_ch0 <= mk(16'h0, 16'h0, 16'hc8, 16'h0);
    wait_for(0, 1'b1, 200);
    check(trip_out, 1'b0, "dt not instant");
    wait_for(1, 1'b1, 200);
    @(posedge clk);
    check(tr_stamp - st_stamp, 32'h3, "dt ms");
    check(prefault, 16'hc8 / 16'h4, "prefault avg");
    calm(16'h3);
    rd_chk(8'h10, 32'h1, "trip count");
    // inverse time: excess 100 shifted by curve 1 adds 200 a ms, k 4 on level 100 trips at 2 ms
    reg_wr(8'h44, 32'h0004_0006);
    set_ch0 <= mk(16'h0, 16'hc8, 16'h0, 16'h0);
    wait_for(1, 1'b1, 200);
    @(posedge clk);
    check(tr_stamp - st_stamp, 32'h2, "idmt ms");
    calm(16'h7);
    reg_wr(8'h44, 32'h0);
    // blocking held, then released live
    block_in <= 1'b1;
    repeat (10) @(posedge clk);
    set_ch0 <= mk(16'hc8, 16'h0, 16'h0, 16'h0);
    wait_for(2, 1'b1, 200);
    check(start_out, 1'b0, "blocked no start");
    rd_chk(8'h14, 32'h1, "blocked count");
    block_in <= 1'b0;
    wait_for(0, 1'b1, 200);
    calm(16'h4);
    // group 1 with a higher level, then back to group 0 while running
    reg_wr(8'h48, 32'h12c);
    reg_wr(8'h4c, 32'h0);
    reg_wr(8'h00, 32'h11);
    set_ch0 <= mk(16'hfa, 16'h0, 16'h0, 16'h0);
    settle();
    check(start_out, 1'b0, "group 1 level");
    rd_chk(8'h08, 32'h110, "status group");
    reg_wr(8'h00, 32'h1);
    wait_for(0, 1'b1, 200);
    calm(16'h5);
    // each magnitude code on channel 1, channel 0 loud but ignored
    for (int i = 0; i < 7; i++) begin
      reg_wr(8'h00, {29'h0, 1'b1, T_SEL[i]});
      set_ch0 <= mk(16'h190, 16'h190, 16'h190, 16'h190);
      set_ch1 <= mk(T_RMS[i], 16'h0, 16'h0, T_TR[i]);
      raw_amp <= T_AMP[i];
      settle();
      check(start_out, T_EXP[i], "magnitude code");
      calm(16'h6);
    end
    conclude();
  end
endmodule : phase_overcurrent_front_end_tb
